/* design/eapr_pkg.sv */
// Package: constants and types for the encoder absolute position range block
package eapr_pkg;
	// ==========================================
	// Parameter register offsets (word indices as printed, byte address is four times)
	localparam logic [15:0] OFS_ADJUST = 16'h052c;
	localparam logic [15:0] OFS_SHIFT = 16'h0542;
	localparam logic [15:0] OFS_DIR_INV = 16'h0618;
	localparam logic [15:0] OFS_ACT_POS = 16'h1e1e;
	localparam logic [15:0] OFS_ABS_ENC = 16'h1e1f;
	localparam logic [15:0] OFS_INDEX_POS = 16'h1e20;
	localparam logic [15:0] OFS_STATUS = 16'h1e21;
	// ==========================================
	// Reset values and encoder figures
	localparam logic [15:0] SHIFT_RST = 16'h0000;
	localparam logic [31:0] ADJUST_RST = 32'h0000_0000;
	localparam int unsigned INCR_PER_TURN = 131072;
	localparam int unsigned TURNS_MT = 4096;
	localparam int unsigned HALF_TURNS_MT = 2048;
	localparam int unsigned X_DEFAULT = 16384;
	localparam int unsigned ST_SHIFT_LO = 65536;
	// Least wait after a write before power may be removed, in ms
	localparam int unsigned PWR_HOLD_MS = 1000;
	localparam int unsigned CLK_MHZ = 125;
	localparam longint unsigned PWR_HOLD_CYC = longint'(PWR_HOLD_MS) * 1000 * CLK_MHZ;
	// ==========================================
	// Types
	typedef enum logic [1:0] {EAPR_BOOT, EAPR_LOAD, EAPR_RUN} eapr_state_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} eapr_req_s;
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} eapr_rsp_s;
endpackage

/* design/eapr_range_chk.sv */
// Range check of an adjustment value against encoder type and shift
`timescale 1ns/1ps
module eapr_range_chk #(
	parameter int unsigned X_USR = eapr_pkg::X_DEFAULT
) (
	input wire logic [31:0] value,
	input wire logic multiturn,
	input wire logic shifted,
	output logic in_range
);
	localparam longint XL = longint'(X_USR);
	longint v;
	longint lo;
	longint hi;
	always_comb begin
		v = longint'($signed(value));
		lo = 0;
		hi = 0;
		// ==========================================
		// Bounds per encoder type and shift
		case ({multiturn, shifted})
			2'b00: begin
				lo = 0;
				hi = XL - 1;
			end
			2'b10: begin
				lo = 0;
				hi = longint'(eapr_pkg::TURNS_MT) * XL - 1;
			end
			2'b01: begin
				lo = -(XL / 2);
				hi = XL / 2 - 1;
			end
			default: begin
				lo = -(longint'(eapr_pkg::HALF_TURNS_MT) * XL);
				hi = longint'(eapr_pkg::HALF_TURNS_MT) * XL - 1;
			end
		endcase
		// Interpreted as a signed 32-bit parameter value
		in_range = (v >= lo) && (v <= hi);
	end
endmodule // eapr_range_chk

/* design/eapr_wrap.sv */
// Wrap of a raw encoder count into the working range
`timescale 1ns/1ps
module eapr_wrap (
	input wire logic [31:0] raw,
	input wire logic multiturn,
	input wire logic shifted,
	output logic [31:0] pos
);
	logic [16:0] st;
	logic [28:0] mt;
	always_comb begin
		st = raw[16:0];
		mt = raw[28:0];
		// ==========================================
		// Modulo the encoder range, optionally sign-extended
		if (multiturn) begin
			pos = shifted ? {{3{mt[28]}}, mt} : {3'h0, mt};
		end else begin
			pos = shifted ? {{15{st[16]}}, st} : {15'h0, st};
		end
	end
endmodule // eapr_wrap

/* design/eapr_top.sv */
// Encoder absolute position handling with adjustment and range shift
`timescale 1ns/1ps
module eapr_top #(
	parameter int unsigned X_USR = eapr_pkg::X_DEFAULT,
	parameter longint unsigned PWR_HOLD_CYCLES = eapr_pkg::PWR_HOLD_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic multiturn,
	input wire logic power_up,
	input wire logic standstill,
	input wire logic [31:0] enc_raw,
	input wire logic enc_step,
	input wire logic enc_dir,
	input wire eapr_pkg::eapr_req_s req,
	output eapr_pkg::eapr_rsp_s rsp,
	output logic [31:0] actual_pos,
	output logic [31:0] index_pos,
	output logic pwr_off_safe
);
	// ==========================================
	// State
	eapr_pkg::eapr_state_e state_r, state_nxt;
	logic [31:0] adj_r, adj_nxt;
	logic [31:0] adj_act_r, adj_act_nxt;
	logic adj_pend_r, adj_pend_nxt;
	logic shift_sel_r, shift_sel_nxt;
	logic shift_act_r, shift_act_nxt;
	logic dir_inv_r, dir_inv_nxt;
	logic dir_act_r, dir_act_nxt;
	logic [31:0] act_r, act_nxt;
	logic [31:0] idx_r, idx_nxt;
	logic [31:0] offs_r, offs_nxt;
	logic [63:0] hold_r, hold_nxt;
	eapr_pkg::eapr_rsp_s rsp_r, rsp_nxt;
	logic ok;
	logic [31:0] wrapped;
	logic [31:0] enc_rel;
	logic adj_take;

	// Encoder count as seen with or without direction inversion
	function automatic logic [31:0] inv_view(input logic [31:0] raw, input logic inv);
		return inv ? (32'h0 - raw) : raw;
	endfunction

	eapr_range_chk #(.X_USR(X_USR)) u_chk (
		.value(req.wdata),
		.multiturn(multiturn),
		.shifted(shift_act_r),
		.in_range(ok)
	);

	eapr_wrap u_wrap (
		.raw(enc_rel),
		.multiturn(multiturn),
		.shifted(shift_act_r),
		.pos(wrapped)
	);

	// Encoder count seen through the adjustment offset and inversion
	assign enc_rel = inv_view(enc_raw, dir_act_r) + offs_r;

	// ==========================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		adj_nxt = adj_r;
		adj_act_nxt = adj_act_r;
		adj_pend_nxt = adj_pend_r;
		shift_sel_nxt = shift_sel_r;
		shift_act_nxt = shift_act_r;
		dir_inv_nxt = dir_inv_r;
		dir_act_nxt = dir_act_r;
		act_nxt = act_r;
		idx_nxt = idx_r;
		offs_nxt = offs_r;
		rsp_nxt = '0;
		case (state_r)
			eapr_pkg::EAPR_BOOT: begin
				// Stored settings become live only here, once per power-up
				shift_act_nxt = shift_sel_r;
				dir_act_nxt = dir_inv_r;
				if (adj_pend_r) begin
					adj_act_nxt = adj_r;
					adj_pend_nxt = 1'b0;
				end
				state_nxt = eapr_pkg::EAPR_LOAD;
			end
			eapr_pkg::EAPR_LOAD: begin
				act_nxt = wrapped;
				state_nxt = eapr_pkg::EAPR_RUN;
			end
			eapr_pkg::EAPR_RUN: begin
				// Free-running count: no wrap, so it goes negative past zero
				if (enc_step) begin
					act_nxt = ((enc_dir ^ dir_act_r) ? act_r - 32'h1 : act_r + 32'h1);
				end
				if (req.wr) begin
					rsp_nxt.ack = 1'b1;
					case (req.addr)
						eapr_pkg::OFS_ADJUST: begin
							// Refused while moving; offset captured for this mechanical point
							if (ok && standstill) begin
								adj_nxt = req.wdata;
								adj_pend_nxt = 1'b1;
								// Offset taken in the inversion live after power-up, so the value lands here then
								offs_nxt = req.wdata - inv_view(enc_raw, dir_inv_r);
								idx_nxt = idx_r + (req.wdata - act_r);
							end else begin
								rsp_nxt.err = 1'b1;
							end
						end
						eapr_pkg::OFS_SHIFT: begin
							if (req.wdata[31:1] == 31'h0) shift_sel_nxt = req.wdata[0];
							else rsp_nxt.err = 1'b1;
						end
						eapr_pkg::OFS_DIR_INV: begin
							if (req.wdata[31:1] == 31'h0) dir_inv_nxt = req.wdata[0];
							else rsp_nxt.err = 1'b1;
						end
						default: rsp_nxt.err = 1'b1;
					endcase
				end else if (req.rd) begin
					rsp_nxt.ack = 1'b1;
					case (req.addr)
						eapr_pkg::OFS_ADJUST: rsp_nxt.rdata = adj_r;
						eapr_pkg::OFS_SHIFT: rsp_nxt.rdata = {31'h0, shift_sel_r};
						eapr_pkg::OFS_DIR_INV: rsp_nxt.rdata = {31'h0, dir_inv_r};
						eapr_pkg::OFS_ACT_POS: rsp_nxt.rdata = act_r;
						eapr_pkg::OFS_ABS_ENC: rsp_nxt.rdata = wrapped;
						eapr_pkg::OFS_INDEX_POS: rsp_nxt.rdata = idx_r;
						eapr_pkg::OFS_STATUS: rsp_nxt.rdata = {29'h0, shift_act_r, adj_pend_r, hold_r == 64'h0};
						default: rsp_nxt.err = 1'b1;
					endcase
				end
			end
			default: state_nxt = eapr_pkg::EAPR_BOOT;
		endcase
		if (power_up) state_nxt = eapr_pkg::EAPR_BOOT;
	end

	// ==========================================
	// Registers
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= eapr_pkg::EAPR_BOOT;
			adj_r <= eapr_pkg::ADJUST_RST;
			adj_act_r <= eapr_pkg::ADJUST_RST;
			adj_pend_r <= 1'b0;
			shift_sel_r <= eapr_pkg::SHIFT_RST[0];
			shift_act_r <= eapr_pkg::SHIFT_RST[0];
			dir_inv_r <= 1'b0;
			dir_act_r <= 1'b0;
			act_r <= 32'h0;
			idx_r <= 32'h0;
			offs_r <= 32'h0;
			rsp_r <= '0;
		end else begin
			state_r <= state_nxt;
			adj_r <= adj_nxt;
			adj_act_r <= adj_act_nxt;
			adj_pend_r <= adj_pend_nxt;
			shift_sel_r <= shift_sel_nxt;
			shift_act_r <= shift_act_nxt;
			dir_inv_r <= dir_inv_nxt;
			dir_act_r <= dir_act_nxt;
			act_r <= act_nxt;
			idx_r <= idx_nxt;
			offs_r <= offs_nxt;
			rsp_r <= rsp_nxt;
		end
	end

	// ==========================================
	// Power-off hold timer
	// Same acceptance terms as the adjust branch above; power_up does not gate either
	assign adj_take = (state_r == eapr_pkg::EAPR_RUN) && req.wr && (req.addr == eapr_pkg::OFS_ADJUST)
		&& ok && standstill;

	// Wide counter so a fast clock or long wait never overflows it
	always_comb begin
		hold_nxt = (hold_r != 64'h0) ? hold_r - 64'h1 : 64'h0;
		// Each accepted adjust write restarts the full wait
		if (adj_take) hold_nxt = PWR_HOLD_CYCLES;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hold_r <= 64'h0;
		end else begin
			hold_r <= hold_nxt;
		end
	end

	assign rsp = rsp_r;
	assign actual_pos = act_r;
	assign index_pos = idx_r;
	assign pwr_off_safe = (hold_r == 64'h0);

	// ==========================================
	// Checks
	sequence s_adj_write;
		req.wr && !req.rd && req.addr == eapr_pkg::OFS_ADJUST && state_r == eapr_pkg::EAPR_RUN && !power_up;
	endsequence

	AST_MOVE_REFUSED: assert property (@(posedge clk) disable iff (srst)
		s_adj_write and !standstill |=> rsp.err && $stable(adj_r)) else $error("adjust taken while moving");
	AST_RANGE_REFUSED: assert property (@(posedge clk) disable iff (srst)
		s_adj_write and !ok |=> rsp.err && $stable(adj_r)) else $error("out of range adjust stored");
	AST_ADJ_TAKEN: assert property (@(posedge clk) disable iff (srst)
		s_adj_write and ok && standstill |=> !rsp.err && adj_r == $past(req.wdata) && adj_pend_r) else $error("adjust lost");
	AST_NOT_IMMEDIATE: assert property (@(posedge clk) disable iff (srst)
		state_r == eapr_pkg::EAPR_RUN && !power_up |=> $stable(adj_act_r) && $stable(shift_act_r))
		else $error("setting live without power-up");
	AST_BOOT_LOAD: assert property (@(posedge clk) disable iff (srst)
		state_r == eapr_pkg::EAPR_LOAD && !power_up |=> act_r == $past(wrapped)) else $error("no reload from encoder");
	AST_COUNT_NEG: assert property (@(posedge clk) disable iff (srst)
		state_r == eapr_pkg::EAPR_RUN && !power_up && enc_step && (enc_dir ^ dir_act_r) && !req.wr
		|=> act_r == $past(act_r) - 32'h1) else $error("count stopped");
	AST_INDEX_SHIFT: assert property (@(posedge clk) disable iff (srst)
		s_adj_write and ok && standstill |=> idx_r - $past(idx_r) == $past(req.wdata) - $past(act_r))
		else $error("index not shifted");
	AST_SHIFT_BOOT: assert property (@(posedge clk) disable iff (srst)
		state_r == eapr_pkg::EAPR_BOOT && !power_up |=> shift_act_r == $past(shift_sel_r)) else $error("shift not applied");
	AST_WRAP_RANGE: assert property (@(posedge clk) disable iff (srst)
		shift_act_r && !multiturn |-> $signed(wrapped) >= -65536 && $signed(wrapped) <= 65535)
		else $error("shifted range broken");
	AST_HOLD: assert property (@(posedge clk) disable iff (srst)
		s_adj_write and ok && standstill |=> !pwr_off_safe) else $error("power-off hold missing");

	// ==========================================
	// Boot chain and stored settings
	sequence s_adj_accept;
		adj_take && !power_up;
	endsequence
	sequence s_boot_pass;
		state_r == eapr_pkg::EAPR_BOOT && !power_up;
	endsequence
	sequence s_load_pass;
		state_r == eapr_pkg::EAPR_LOAD && !power_up;
	endsequence
	sequence s_shift_write;
		req.wr && req.addr == eapr_pkg::OFS_SHIFT && state_r == eapr_pkg::EAPR_RUN;
	endsequence

	// Shift and inversion are copied once per power-up, the adjust only while one is pending
	AST_POWER_REBOOT: assert property (@(posedge clk) disable iff (srst)
		power_up |=> state_r == eapr_pkg::EAPR_BOOT) else $error("power-up did not restart");
	AST_BOOT_ORDER: assert property (@(posedge clk) disable iff (srst)
		s_boot_pass |=> state_r == eapr_pkg::EAPR_LOAD) else $error("boot did not lead to load");
	AST_LOAD_ORDER: assert property (@(posedge clk) disable iff (srst)
		s_load_pass |=> state_r == eapr_pkg::EAPR_RUN) else $error("load did not lead to run");
	AST_NO_ANSWER: assert property (@(posedge clk) disable iff (srst)
		state_r != eapr_pkg::EAPR_RUN |=> !rsp.ack) else $error("answer outside run");
	AST_ADJ_LIVE: assert property (@(posedge clk) disable iff (srst)
		s_boot_pass and adj_pend_r |=> adj_act_r == $past(adj_r) && !adj_pend_r)
		else $error("pending adjust not applied");
	AST_PEND_KEPT: assert property (@(posedge clk) disable iff (srst)
		state_r == eapr_pkg::EAPR_RUN && adj_pend_r |=> adj_pend_r) else $error("pending adjust dropped");
	AST_DIR_BOOT: assert property (@(posedge clk) disable iff (srst)
		s_boot_pass |=> dir_act_r == $past(dir_inv_r)) else $error("inversion not applied");
	AST_SHIFT_BAD: assert property (@(posedge clk) disable iff (srst)
		s_shift_write and req.wdata[31:1] != 31'h0 |=> rsp.err && $stable(shift_sel_r))
		else $error("bad shift code stored");
	AST_SHIFT_GOOD: assert property (@(posedge clk) disable iff (srst)
		s_shift_write and req.wdata[31:1] == 31'h0 |=> !rsp.err && shift_sel_r == $past(req.wdata[0]))
		else $error("shift code lost");

	// ==========================================
	// Position view
	// Range checks guard against a width slip in the wrap, not against traffic
	AST_WRAP_ST: assert property (@(posedge clk) disable iff (srst)
		!shift_act_r && !multiturn |-> wrapped <= 32'h0001_ffff) else $error("singleturn range broken");
	AST_WRAP_MT: assert property (@(posedge clk) disable iff (srst)
		!shift_act_r && multiturn |-> wrapped[31:29] == 3'h0) else $error("multiturn range broken");
	AST_WRAP_MT_SHIFT: assert property (@(posedge clk) disable iff (srst)
		shift_act_r && multiturn |-> $signed(wrapped) >= -268435456 && $signed(wrapped) <= 268435455)
		else $error("shifted multiturn range broken");
	// Only meaningful while no inversion change is pending
	AST_ABS_TAKE: assert property (@(posedge clk) disable iff (srst)
		s_adj_accept and dir_inv_r == dir_act_r |=> (($stable(enc_raw) && $stable(multiturn))
		|-> wrapped == $past(req.wdata))) else $error("adjust not placed at current position");
	AST_INDEX_STILL: assert property (@(posedge clk) disable iff (srst)
		!adj_take |=> $stable(idx_r)) else $error("index moved without adjust");
	AST_HOLD_DOWN: assert property (@(posedge clk) disable iff (srst)
		!pwr_off_safe && !adj_take |=> hold_r == $past(hold_r) - 64'h1) else $error("hold timer stalled");
endmodule // eapr_top

/* tb/eapr_enc_model.sv */
// Behavioural encoder at the block's far side
`timescale 1ns/1ps
module eapr_enc_model (
	input wire logic clk,
	output logic [31:0] enc_raw,
	output logic enc_step,
	output logic enc_dir
);
	// ==========================================
	// Stepping
	initial begin
		enc_raw = 32'h0000_0100;
		enc_step = 1'b0;
		enc_dir = 1'b0;
	end
	// Steps are one-cycle pulses with a gap, raw count follows each step
	task automatic move(input int n, input logic neg);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			enc_step = 1'b1;
			enc_dir = neg;
			enc_raw = neg ? enc_raw - 32'h1 : enc_raw + 32'h1;
			@(negedge clk);
			enc_step = 1'b0;
		end
	endtask
endmodule // eapr_enc_model

/* tb/test_encoder_absolute_position_range.sv */
// Testbench for the encoder absolute position block
`timescale 1ns/1ps
module test_encoder_absolute_position_range;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic multiturn = 1'b0;
	logic power_up = 1'b0;
	logic standstill = 1'b1;
	logic [31:0] enc_raw;
	logic enc_step;
	logic enc_dir;
	eapr_pkg::eapr_req_s req = '0;
	eapr_pkg::eapr_rsp_s rsp;
	logic [31:0] actual_pos;
	logic [31:0] index_pos;
	logic pwr_off_safe;
	logic [31:0] p;
	int fail_count = 0;
	int checks_done = 0;
	always #4 clk = ~clk;
	// Short hold keeps the run small
	eapr_top #(.X_USR(16384), .PWR_HOLD_CYCLES(20)) eapr_top_i (.clk(clk), .srst(srst), .multiturn(multiturn),
		.power_up(power_up), .standstill(standstill), .enc_raw(enc_raw), .enc_step(enc_step), .enc_dir(enc_dir),
		.req(req), .rsp(rsp), .actual_pos(actual_pos), .index_pos(index_pos), .pwr_off_safe(pwr_off_safe));
	eapr_enc_model eapr_enc_model_i (.clk(clk), .enc_raw(enc_raw), .enc_step(enc_step), .enc_dir(enc_dir));
	// ==========================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		int k;
		@(negedge clk);
		req = '{wr: wr, rd: !wr, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
		for (k = 0; k < 4 && rsp.ack !== 1'b1; k++) @(negedge clk);
		check({31'h0, rsp.ack}, 32'h1);
		rd = rsp.rdata;
		er = rsp.err;
	endtask
	task automatic wr_chk(input logic [15:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] rd;
		logic er;
		access(1'b1, a, d, rd, er);
		check({31'h0, er}, {31'h0, exp_err});
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic er;
		access(1'b0, a, 32'h0, rd, er);
		check({31'h0, er}, {31'h0, exp_err});
		check(rd, exp);
	endtask
	task automatic power_cycle();
		int k;
		// Power may only drop once the post-write wait has run out
		for (k = 0; k < 40 && pwr_off_safe !== 1'b1; k++) @(negedge clk);
		check({31'h0, pwr_off_safe}, 32'h1);
		@(negedge clk);
		power_up = 1'b1;
		@(negedge clk);
		power_up = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ==========================================
	// Watchdog
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		finish_test();
	end
	// ==========================================
	// Tests
	initial begin
		repeat (2) @(negedge clk);
		srst = 1'b0;
		repeat (3) @(negedge clk);
		rd_chk(eapr_pkg::OFS_SHIFT, 32'h0, 1'b0);
		check({31'h0, pwr_off_safe}, 32'h1);
		$display("test reset done");
		p = actual_pos;
		wr_chk(eapr_pkg::OFS_ADJUST, 32'h0000_4000, 1'b1);
		rd_chk(eapr_pkg::OFS_ADJUST, 32'h0, 1'b0);
		wr_chk(eapr_pkg::OFS_ADJUST, 32'h0000_3fff, 1'b0);
		check(index_pos, 32'h0000_3fff - p);
		check({31'h0, pwr_off_safe}, 32'h0);
		check(actual_pos, p);
		repeat (25) @(negedge clk);
		check({31'h0, pwr_off_safe}, 32'h1);
		multiturn = 1'b1;
		wr_chk(eapr_pkg::OFS_ADJUST, 32'h0400_0000, 1'b1);
		wr_chk(eapr_pkg::OFS_ADJUST, 32'h03ff_ffff, 1'b0);
		standstill = 1'b0;
		wr_chk(eapr_pkg::OFS_ADJUST, 32'h0000_0005, 1'b1);
		rd_chk(eapr_pkg::OFS_ADJUST, 32'h03ff_ffff, 1'b0);
		standstill = 1'b1;
		$display("test adjust done");
		wr_chk(eapr_pkg::OFS_SHIFT, 32'h2, 1'b1);
		wr_chk(eapr_pkg::OFS_SHIFT, 32'h1, 1'b0);
		multiturn = 1'b0;
		wr_chk(eapr_pkg::OFS_ADJUST, 32'hffff_e000, 1'b1);
		power_cycle();
		check(actual_pos, 32'hffff_ffff);
		wr_chk(eapr_pkg::OFS_ADJUST, 32'hffff_e000, 1'b0);
		wr_chk(eapr_pkg::OFS_ADJUST, 32'h0000_2000, 1'b1);
		multiturn = 1'b1;
		wr_chk(eapr_pkg::OFS_ADJUST, 32'hfe00_0000, 1'b0);
		wr_chk(eapr_pkg::OFS_ADJUST, 32'h0200_0000, 1'b1);
		$display("test shift done");
		p = actual_pos;
		eapr_enc_model_i.move(3, 1'b1);
		@(negedge clk);
		check(actual_pos, p - 32'h3);
		rd_chk(16'h0001, 32'h0, 1'b1);
		$display("test underrun done");
		wr_chk(eapr_pkg::OFS_DIR_INV, 32'h1, 1'b0);
		wr_chk(eapr_pkg::OFS_ADJUST, 32'h0000_0010, 1'b0);
		power_cycle();
		check(actual_pos, 32'h0000_0010);
		eapr_enc_model_i.move(18, 1'b0);
		@(negedge clk);
		check(actual_pos, 32'hffff_fffe);
		rd_chk(eapr_pkg::OFS_ABS_ENC, 32'hffff_fffe, 1'b0);
		$display("test inversion done");
		finish_test();
	end
endmodule // test_encoder_absolute_position_range
